// ==== common/pmb_pkg.sv ====
// Purpose: Shared constants and carriers of the memory-mapped link bridge.
// Assumes: 64-bit fabric data path, qword-aligned fabric requests.
// Notes:   Identification values are not used by this block.

// ==========================================================================
// Package
package pmb_pkg;
  localparam int unsigned DW           = 64;
  localparam logic [9:0]  MAX_BURST_B  = 10'h200;
  localparam logic [9:0]  MAX_RD_B     = 10'h100;
  localparam logic [9:0]  PAYLOAD_MIN_B = 10'h080;
  localparam logic [12:0] BOUND_4K     = 13'h1000;
  localparam logic [6:0]  MAX_BEATS    = 7'h40;
  localparam logic [6:0]  CR_SINGLE    = 7'h01;
  localparam int unsigned NXLAT        = 4;
  localparam logic [2:0]  NBAR         = 3'h6;
  localparam logic [44:0] XLAT_RST     = 45'h0;
  localparam logic [31:0] BAR_BASE [6] = '{32'h0000_0000, 32'h0010_0000, 32'h0020_0000,
                                           32'h0030_0000, 32'h0040_0000, 32'h0050_0000};
  localparam logic [31:0] BAR_MASK [6] = '{32'h000f_ffff, 32'h000f_ffff, 32'h000f_ffff,
                                           32'h000f_ffff, 32'h000f_ffff, 32'h000f_ffff};

  typedef enum logic [2:0] {PMB_MEM_RD, PMB_MEM_WR, PMB_VDM0, PMB_VDM1, PMB_FLUSH, PMB_OTHER} pmb_rx_kind_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [6:0]  burstcount;
    logic [7:0]  byteenable;
    logic [63:0] writedata;
  } pmb_av_req_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [6:0]  burstcount;
    logic [31:0] writedata;
  } pmb_cr_req_s;

  typedef struct packed {
    logic [63:20] base;
    logic         sp64;
  } pmb_xlat_s;

  typedef struct packed {
    logic        is_write;
    logic        addr64;
    logic [63:0] addr;
    logic [7:0]  len_dw;
    logic [5:0]  tag;
  } pmb_tx_hdr_s;

  typedef struct packed {
    logic [5:0]  tag;
    logic [5:0]  beat;
    logic [63:0] data;
  } pmb_cpl_beat_s;

  typedef struct packed {
    pmb_rx_kind_e kind;
    logic [2:0]   bar;
    logic [31:0]  offset;
    logic [12:0]  len_bytes;
  } pmb_rx_hdr_s;

  typedef struct packed {
    logic abort;
    logic flush;
  } pmb_cpl_hdr_s;
endpackage

// ==== logic/pmb_bridge.sv ====
// Purpose: Link-to-fabric bridge with bursting slave, bursting master and control port.
// Assumes: Fabric slave requests are qword aligned; one read is outstanding at a time.
// Notes:   Control port holds the translation table.
// Operation
// - Slave accepts write bursts up to 512 bytes.
// - Writes become packets, 32 or 64-bit addressed.
// - Writes crossing 4K are split there.
// - Write packets never exceed maximum payload.
// - Reads become packets, 32 or 64-bit addressed.
// - Slave accepts read bursts up to 512 bytes.
// - Link read packets request at most 256 bytes.
// - Link read packets never cross 4K.
// - Invalid requests other than link writes complete with abort status.
// - Vendor messages of both types are dropped.
// - Flush gets completion, never reaches fabric.
// - Each BAR maps one fixed fabric range.
// - Master turns link requests into fabric bursts.
// - Slave carries fabric reads, writes toward link.
// - Control port is 32-bit, single dword only.
// - Control port always present for translation.
// - Read data returns in issue order.
// - Fabric reads from link at most 512 bytes.
`timescale 1ns/100ps
module pmb_bridge (
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire pmb_pkg::pmb_av_req_s  slv_req_in,
  output logic                       slv_waitrequest_out,
  output logic                       slv_rvalid_out,
  output logic [63:0]                slv_rdata_out,
  output logic                       slv_rabort_out,
  output logic                       slv_wabort_out,
  input  wire logic [1:0]            max_payload_in,
  output pmb_pkg::pmb_tx_hdr_s       tx_hdr_out,
  output logic                       tx_hdr_valid_out,
  input  wire logic                  tx_hdr_ready_in,
  output logic [63:0]                tx_data_out,
  output logic [7:0]                 tx_be_out,
  output logic                       tx_data_valid_out,
  input  wire logic                  tx_data_ready_in,
  input  wire pmb_pkg::pmb_cpl_beat_s cpl_in,
  input  wire logic                  cpl_valid_in,
  input  wire pmb_pkg::pmb_rx_hdr_s  rx_hdr_in,
  input  wire logic                  rx_hdr_valid_in,
  output logic                       rx_hdr_ready_out,
  input  wire logic [63:0]           rx_data_in,
  input  wire logic [7:0]            rx_be_in,
  input  wire logic                  rx_data_valid_in,
  output logic                       rx_data_ready_out,
  output pmb_pkg::pmb_cpl_hdr_s      cpl_hdr_out,
  output logic                       cpl_hdr_valid_out,
  output logic [63:0]                cpl_data_out,
  output logic                       cpl_data_valid_out,
  output pmb_pkg::pmb_av_req_s       mst_req_out,
  input  wire logic                  mst_waitrequest_in,
  input  wire logic                  mst_rvalid_in,
  input  wire logic [63:0]           mst_rdata_in,
  input  wire pmb_pkg::pmb_cr_req_s  cr_req_in,
  output logic [31:0]                cr_rdata_out,
  output logic                       cr_rvalid_out,
  output logic                       cr_err_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ========================================================================
  // Control port and translation table
  pmb_pkg::pmb_xlat_s xlat [pmb_pkg::NXLAT];
  pmb_pkg::pmb_xlat_s next_xlat [pmb_pkg::NXLAT];
  logic [31:0] next_cr_rdata;
  logic        next_cr_rvalid, next_cr_err, cr_ok;
  logic [1:0]  cr_ent;

  always_comb begin
    next_xlat = xlat;
    cr_ent = cr_req_in.address[4:3];
    cr_ok = (cr_req_in.burstcount == pmb_pkg::CR_SINGLE) && !cr_req_in.address[5];
    next_cr_rvalid = cr_req_in.read;
    next_cr_err = (cr_req_in.read || cr_req_in.write) && !cr_ok;
    next_cr_rdata = 32'h0;
    if (cr_req_in.write && cr_ok) begin
      if (cr_req_in.address[2]) begin
        next_xlat[cr_ent].base[63:32] = cr_req_in.writedata;
      end else begin
        next_xlat[cr_ent].base[31:20] = cr_req_in.writedata[31:20];
        next_xlat[cr_ent].sp64 = cr_req_in.writedata[0];
      end
    end
    if (cr_req_in.read && cr_ok) begin
      next_cr_rdata = cr_req_in.address[2] ? xlat[cr_ent].base[63:32]
                                           : {xlat[cr_ent].base[31:20], 19'h0, xlat[cr_ent].sp64};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < pmb_pkg::NXLAT; i++) begin
        xlat[i] <= pmb_pkg::XLAT_RST;
      end
      cr_rdata_out <= 32'h0;
      cr_rvalid_out <= 1'b0;
      cr_err_out <= 1'b0;
    end else begin
      xlat <= next_xlat;
      cr_rdata_out <= next_cr_rdata;
      cr_rvalid_out <= next_cr_rvalid;
      cr_err_out <= next_cr_err;
    end
  end

  a_cr_single: assert property ((cr_req_in.read || cr_req_in.write) && cr_req_in.burstcount != 7'h01 |=>
    cr_err_out)
    else $error("Control port accepted a burst.");

  // ========================================================================
  // Fabric slave to link requests
  typedef enum {S_IDLE, S_SPLIT, S_DATA, S_ACC, S_ABORT, S_RET} pmb_slv_st_e;
  pmb_slv_st_e s_st, next_s_st;
  logic        s_rd, next_s_rd, s_abort, next_s_abort;
  logic [31:0] s_addr, next_s_addr;
  logic [6:0]  s_burst, next_s_burst, s_rem, next_s_rem, s_left, next_s_left, rptr, next_rptr;
  logic [6:0]  seg, lim_beats;
  logic [12:0] gap4k;
  logic [9:0]  limb;
  logic        hdr_free, dat_free, req_ok, take;
  logic [63:0] taddr;
  pmb_pkg::pmb_xlat_s xl;
  pmb_pkg::pmb_tx_hdr_s next_tx_hdr;
  logic        next_tx_hdr_valid, next_tx_dvalid, next_rvalid, next_rabort, next_wabort;
  logic [63:0] next_tx_data, next_rdata;
  logic [7:0]  next_tx_be;
  logic [63:0] buf_data [64];
  logic        buf_vld [64];
  logic [5:0]  cpl_pos;

  always_comb begin
    hdr_free = !tx_hdr_valid_out || tx_hdr_ready_in;
    dat_free = !tx_data_valid_out || tx_data_ready_in;
    req_ok = (slv_req_in.address[31:22] == 10'h0) && (slv_req_in.address[2:0] == 3'h0) &&
             (slv_req_in.burstcount != 7'h0) && (slv_req_in.burstcount <= pmb_pkg::MAX_BEATS);
    if (s_rd) begin
      limb = pmb_pkg::MAX_RD_B;
    end else if (max_payload_in == 2'h3) begin
      limb = pmb_pkg::MAX_BURST_B;
    end else begin
      limb = pmb_pkg::PAYLOAD_MIN_B << max_payload_in;
    end
    lim_beats = limb[9:3];
    gap4k = pmb_pkg::BOUND_4K - {1'b0, s_addr[11:0]};
    seg = s_rem;
    if (seg > lim_beats) begin
      seg = lim_beats;
    end
    if ({3'h0, seg} > gap4k[12:3]) begin
      seg = gap4k[9:3];
    end
    xl = xlat[s_addr[21:20]];
    taddr = {xl.base, s_addr[19:0]};
    take = (s_st == S_RET) && (s_abort || buf_vld[rptr[5:0]]);
  end

  always_comb begin
    next_s_st = s_st;
    next_s_rd = s_rd;
    next_s_abort = s_abort;
    next_s_addr = s_addr;
    next_s_burst = s_burst;
    next_s_rem = s_rem;
    next_s_left = s_left;
    next_rptr = rptr;
    next_tx_hdr = tx_hdr_out;
    next_tx_hdr_valid = tx_hdr_valid_out && !tx_hdr_ready_in;
    next_tx_data = tx_data_out;
    next_tx_be = tx_be_out;
    next_tx_dvalid = tx_data_valid_out && !tx_data_ready_in;
    next_rvalid = 1'b0;
    next_rdata = slv_rdata_out;
    next_rabort = 1'b0;
    next_wabort = 1'b0;
    slv_waitrequest_out = 1'b1;
    case (s_st)
      S_IDLE: begin
        if (slv_req_in.read || slv_req_in.write) begin
          next_s_rd = slv_req_in.read;
          next_s_addr = slv_req_in.address;
          next_s_burst = slv_req_in.burstcount;
          next_s_rem = slv_req_in.burstcount;
          next_s_abort = !req_ok;
          next_s_st = req_ok ? S_SPLIT : S_ABORT;
        end
      end
      S_SPLIT: begin
        if (hdr_free) begin
          next_tx_hdr.is_write = !s_rd;
          next_tx_hdr.addr64 = xl.sp64 && (taddr[63:32] != 32'h0);
          next_tx_hdr.addr = taddr;
          next_tx_hdr.len_dw = {seg, 1'b0};
          next_tx_hdr.tag = 6'(s_burst - s_rem);
          next_tx_hdr_valid = 1'b1;
          next_s_addr = s_addr + {22'h0, seg, 3'h0};
          next_s_rem = s_rem - seg;
          next_s_left = seg;
          if (!s_rd) begin
            next_s_st = S_DATA;
          end else if (s_rem == seg) begin
            next_s_st = S_ACC;
          end
        end
      end
      S_DATA: begin
        slv_waitrequest_out = !dat_free;
        if (slv_req_in.write && dat_free) begin
          next_tx_data = slv_req_in.writedata;
          next_tx_be = slv_req_in.byteenable;
          next_tx_dvalid = 1'b1;
          next_s_left = s_left - 7'h1;
          if (s_left == 7'h1) begin
            next_s_st = (s_rem == 7'h0) ? S_IDLE : S_SPLIT;
          end
        end
      end
      S_ACC: begin
        slv_waitrequest_out = 1'b0;
        next_rptr = 7'h0;
        next_s_st = S_RET;
      end
      S_ABORT: begin
        slv_waitrequest_out = 1'b0;
        if (s_rd) begin
          next_rptr = 7'h0;
          next_s_st = S_RET;
        end else if (slv_req_in.write) begin
          next_s_rem = s_rem - 7'h1;
          if (s_rem == 7'h1 || s_rem == 7'h0) begin
            next_wabort = 1'b1;
            next_s_st = S_IDLE;
          end
        end
      end
      S_RET: begin
        if (take) begin
          next_rvalid = 1'b1;
          next_rabort = s_abort;
          next_rdata = s_abort ? 64'h0 : buf_data[rptr[5:0]];
          next_rptr = rptr + 7'h1;
          if (rptr + 7'h1 >= s_burst) begin
            next_s_st = S_IDLE;
          end
        end
      end
      default: next_s_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_st <= S_IDLE;
      s_rd <= 1'b0;
      s_abort <= 1'b0;
      s_addr <= 32'h0;
      s_burst <= 7'h0;
      s_rem <= 7'h0;
      s_left <= 7'h0;
      rptr <= 7'h0;
      tx_hdr_out <= '0;
      tx_hdr_valid_out <= 1'b0;
      tx_data_out <= 64'h0;
      tx_be_out <= 8'h0;
      tx_data_valid_out <= 1'b0;
      slv_rvalid_out <= 1'b0;
      slv_rdata_out <= 64'h0;
      slv_rabort_out <= 1'b0;
      slv_wabort_out <= 1'b0;
    end else begin
      s_st <= next_s_st;
      s_rd <= next_s_rd;
      s_abort <= next_s_abort;
      s_addr <= next_s_addr;
      s_burst <= next_s_burst;
      s_rem <= next_s_rem;
      s_left <= next_s_left;
      rptr <= next_rptr;
      tx_hdr_out <= next_tx_hdr;
      tx_hdr_valid_out <= next_tx_hdr_valid;
      tx_data_out <= next_tx_data;
      tx_be_out <= next_tx_be;
      tx_data_valid_out <= next_tx_dvalid;
      slv_rvalid_out <= next_rvalid;
      slv_rdata_out <= next_rdata;
      slv_rabort_out <= next_rabort;
      slv_wabort_out <= next_wabort;
    end
  end

  assign cpl_pos = cpl_in.tag + cpl_in.beat;
  for (genvar i = 0; i < 64; i++) begin : g_rbuf
    logic        next_vld, hit;
    logic [63:0] next_data;
    always_comb begin
      hit = cpl_valid_in && (cpl_pos == 6'(i));
      next_vld = hit || (buf_vld[i] && !(take && !s_abort && rptr[5:0] == 6'(i)));
      next_data = hit ? cpl_in.data : buf_data[i];
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        buf_vld[i] <= 1'b0;
        buf_data[i] <= 64'h0;
      end else begin
        buf_vld[i] <= next_vld;
        buf_data[i] <= next_data;
      end
    end
  end

  a_rd_len_max: assert property (tx_hdr_valid_out && !tx_hdr_out.is_write |-> tx_hdr_out.len_dw <= 8'h40)
    else $error("Read packet above 256 bytes.");
  a_rd_no_4k: assert property (tx_hdr_valid_out && !tx_hdr_out.is_write |->
    ({1'b0, tx_hdr_out.addr[11:0]} + {3'h0, tx_hdr_out.len_dw, 2'h0}) <= 13'h1000)
    else $error("Read packet crosses 4K.");
  a_wr_no_4k: assert property (tx_hdr_valid_out && tx_hdr_out.is_write |->
    ({1'b0, tx_hdr_out.addr[11:0]} + {3'h0, tx_hdr_out.len_dw, 2'h0}) <= 13'h1000)
    else $error("Write packet crosses 4K.");
  a_wr_payload: assert property (tx_hdr_valid_out && tx_hdr_out.is_write |->
    {tx_hdr_out.len_dw, 2'h0} <= ((max_payload_in == 2'h3) ? 10'h200 : (10'h080 << max_payload_in)))
    else $error("Write packet above payload.");
  a_split_stall: assert property (s_st == S_SPLIT |-> slv_waitrequest_out)
    else $error("Slave not stalled while splitting.");
  a_seg_ascend: assert property (s_st == S_SPLIT && hdr_free |=>
    s_addr == $past(s_addr) + {22'h0, $past(seg), 3'h0} && tx_hdr_out.len_dw == {$past(seg), 1'b0})
    else $error("Segment address or length wrong.");
  a_rd_abort: assert property (s_st == S_ABORT && s_rd |=> ##1 slv_rvalid_out && slv_rabort_out)
    else $error("Invalid read not aborted.");
  c_split_rd: cover property (tx_hdr_valid_out && !tx_hdr_out.is_write && tx_hdr_out.tag != 6'h0);
  c_wr_abort: cover property (slv_wabort_out);

  // ========================================================================
  // Link requests to fabric master
  typedef enum {M_IDLE, M_RD, M_WR, M_DROP, M_CPL} pmb_mst_st_e;
  pmb_mst_st_e m_st, next_m_st;
  logic [31:0] m_addr, next_m_addr;
  logic [9:0]  m_rem, next_m_rem;
  logic [6:0]  m_wburst, next_m_wburst, mburst;
  logic        bar_ok, m_ok;
  logic [2:0]  bi;
  logic [9:0]  rx_beats;
  pmb_pkg::pmb_cpl_hdr_s next_cpl_hdr;
  logic        next_cpl_hdr_valid;

  always_comb begin
    bar_ok = rx_hdr_in.bar < pmb_pkg::NBAR;
    bi = bar_ok ? rx_hdr_in.bar : 3'h0;
    rx_beats = rx_hdr_in.len_bytes[12:3];
    m_ok = bar_ok && (rx_beats != 10'h0);
    mburst = (m_rem > {3'h0, pmb_pkg::MAX_BEATS}) ? pmb_pkg::MAX_BEATS : m_rem[6:0];
    next_m_st = m_st;
    next_m_addr = m_addr;
    next_m_rem = m_rem;
    next_m_wburst = m_wburst;
    next_cpl_hdr = cpl_hdr_out;
    next_cpl_hdr_valid = 1'b0;
    rx_hdr_ready_out = 1'b0;
    rx_data_ready_out = 1'b0;
    case (m_st)
      M_IDLE: begin
        rx_hdr_ready_out = 1'b1;
        if (rx_hdr_valid_in) begin
          next_m_addr = pmb_pkg::BAR_BASE[bi] | (rx_hdr_in.offset & pmb_pkg::BAR_MASK[bi]);
          next_m_rem = rx_beats;
          next_m_wburst = (rx_beats > {3'h0, pmb_pkg::MAX_BEATS}) ? pmb_pkg::MAX_BEATS : rx_beats[6:0];
          next_cpl_hdr = '0;
          case (rx_hdr_in.kind)
            pmb_pkg::PMB_MEM_RD: next_m_st = m_ok ? M_RD : M_CPL;
            pmb_pkg::PMB_MEM_WR: next_m_st = m_ok ? M_WR : M_DROP;
            pmb_pkg::PMB_VDM0, pmb_pkg::PMB_VDM1: next_m_st = M_IDLE;
            pmb_pkg::PMB_FLUSH: begin
              next_cpl_hdr.flush = 1'b1;
              next_m_st = M_CPL;
            end
            default: next_m_st = M_CPL;
          endcase
          next_cpl_hdr.abort = !(rx_hdr_in.kind == pmb_pkg::PMB_FLUSH);
        end
      end
      M_RD: begin
        if (!mst_waitrequest_in) begin
          next_m_addr = m_addr + {22'h0, mburst, 3'h0};
          next_m_rem = m_rem - {3'h0, mburst};
          if (m_rem == {3'h0, mburst}) begin
            next_m_st = M_IDLE;
          end
        end
      end
      M_WR, M_DROP: begin
        rx_data_ready_out = (m_st == M_DROP) || !mst_waitrequest_in;
        if (rx_data_valid_in && rx_data_ready_out) begin
          next_m_rem = m_rem - 10'h1;
          if (m_rem == 10'h1) begin
            next_m_st = M_IDLE;
          end
        end
      end
      M_CPL: begin
        next_cpl_hdr_valid = 1'b1;
        next_m_st = M_IDLE;
      end
      default: next_m_st = M_IDLE;
    endcase
    mst_req_out.read = (m_st == M_RD);
    mst_req_out.write = (m_st == M_WR) && rx_data_valid_in;
    mst_req_out.address = m_addr;
    mst_req_out.burstcount = (m_st == M_WR) ? m_wburst : mburst;
    mst_req_out.byteenable = (m_st == M_WR) ? rx_be_in : 8'hff;
    mst_req_out.writedata = rx_data_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      m_st <= M_IDLE;
      m_addr <= 32'h0;
      m_rem <= 10'h0;
      m_wburst <= 7'h0;
      cpl_hdr_out <= '0;
      cpl_hdr_valid_out <= 1'b0;
      cpl_data_out <= 64'h0;
      cpl_data_valid_out <= 1'b0;
    end else begin
      m_st <= next_m_st;
      m_addr <= next_m_addr;
      m_rem <= next_m_rem;
      m_wburst <= next_m_wburst;
      cpl_hdr_out <= next_cpl_hdr;
      cpl_hdr_valid_out <= next_cpl_hdr_valid;
      cpl_data_out <= mst_rdata_in;
      cpl_data_valid_out <= mst_rvalid_in;
    end
  end

  a_vdm_drop: assert property (m_st == M_IDLE && rx_hdr_valid_in &&
    (rx_hdr_in.kind == pmb_pkg::PMB_VDM0 || rx_hdr_in.kind == pmb_pkg::PMB_VDM1) |=>
    !mst_req_out.read && !mst_req_out.write && m_st == M_IDLE)
    else $error("Vendor message reached fabric.");
  a_flush_cpl: assert property (m_st == M_IDLE && rx_hdr_valid_in && rx_hdr_in.kind == pmb_pkg::PMB_FLUSH |=>
    !mst_req_out.read ##1 cpl_hdr_valid_out && cpl_hdr_out.flush && !cpl_hdr_out.abort)
    else $error("Flush not completed locally.");
  a_mst_burst: assert property (mst_req_out.read |-> mst_req_out.burstcount <= 7'h40 &&
    mst_req_out.burstcount != 7'h0)
    else $error("Fabric read burst out of range.");
  c_flush: cover property (cpl_hdr_valid_out && cpl_hdr_out.flush);
endmodule // pmb_bridge

// ==== testbench/pmb_link_fabric_model.sv ====
// Purpose: Link completer and fabric slave beside the bridge.
// Assumes: Read segments are answered late, newest segment first.
// Notes:   Idle lines show the inverse of their last value.
`timescale 1ns/100ps
module pmb_link_fabric_model (
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  input  wire pmb_pkg::pmb_tx_hdr_s hdr_in,
  input  wire logic                 take_in,
  input  wire pmb_pkg::pmb_av_req_s mreq_in,
  output pmb_pkg::pmb_cpl_beat_s    cpl_out,
  output logic                      cpl_valid_out,
  output logic                      wait_out,
  output logic                      rvalid_out,
  output logic [63:0]               rdata_out
);
  logic [13:0] segs[$];
  logic [13:0] seg;
  logic [31:0] rq[$];
  logic [3:0]  n;
  int          idle;
  initial begin
    {cpl_out, cpl_valid_out, wait_out, rvalid_out, rdata_out, n, idle} = '0;
  end
  // ====
  // Fabric slave stalls one cycle in four and returns each beat's address as data.
  always @(posedge clk_in) begin
    n <= n + 4'h1;
    wait_out <= (n[1:0] == 2'h0);
    idle <= take_in ? 0 : idle + 1;
    if (take_in && !hdr_in.is_write && arst_n_in) segs.push_back({hdr_in.tag, hdr_in.len_dw});
    if (rq.size() > 0) begin
      rvalid_out <= 1'b1;
      rdata_out <= 64'(rq.pop_front());
    end else begin
      rvalid_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end
    if (mreq_in.read && !wait_out && arst_n_in)
      for (int b = 0; b < int'(mreq_in.burstcount); b++) rq.push_back(mreq_in.address + 32'(8 * b));
  end
  // Completer answers the newest read segment first.
  initial forever begin
    @(posedge clk_in);
    if (segs.size() > 0 && idle > 8) begin
      seg = segs.pop_back();
      for (int b = 0; b < seg[7:1]; b++) begin
        cpl_out <= '{seg[13:8], 6'(b), 64'hc0de_0000_0000_0000 | 64'(seg[13:8] + 6'(b))};
        cpl_valid_out <= 1'b1;
        @(posedge clk_in);
      end
      cpl_valid_out <= 1'b0;
      cpl_out <= ~cpl_out;
    end
  end
endmodule // pmb_link_fabric_model

// ==== testbench/tb_pmb_bridge.sv ====
// Purpose: Self-checking bench of the link bridge.
// Assumes: Translation entry 3 is loaded first.
// Notes:   Drivers queue results, one watcher compares them.
`timescale 1ns/100ps
module tb_pmb_bridge;
  logic                   clk_in = 0, arst_n_in = 0, hr = 1, dr = 1, rx_hv = 0, rx_dv = 0;
  logic                   wreq, rv, rab, wab, hv, dv, rx_hr, rx_dr, chv, cdv, mw, mrv, cv, crv, cre;
  logic [63:0]            rd, td, cd, md, rx_d = '0;
  logic [7:0]             tbe;
  logic [31:0]            crd;
  logic [15:0]            lfsr = 16'h0010;
  logic [1:0]             mp = 2'h0;
  pmb_pkg::pmb_av_req_s   sreq = '0, mreq;
  pmb_pkg::pmb_tx_hdr_s   th;
  pmb_pkg::pmb_cpl_beat_s cpl;
  pmb_pkg::pmb_rx_hdr_s   rh = '0;
  pmb_pkg::pmb_cr_req_s   cr = '0;
  pmb_pkg::pmb_cpl_hdr_s  ch;
  logic [95:0]            q_th[$], q_sl[$], q_m[$], q_c[$], q_cr[$], q_d[$], q_td[$];
  int                     miscompares = 0, n_compared = 0;
  pmb_bridge i_pmb_bridge (.clk_in(clk_in), .arst_n_in(arst_n_in), .slv_req_in(sreq), .slv_waitrequest_out(wreq),
    .slv_rvalid_out(rv), .slv_rdata_out(rd), .slv_rabort_out(rab), .slv_wabort_out(wab), .max_payload_in(mp),
    .tx_hdr_out(th), .tx_hdr_valid_out(hv), .tx_hdr_ready_in(hr), .tx_data_out(td), .tx_be_out(tbe),
    .tx_data_valid_out(dv), .tx_data_ready_in(dr), .cpl_in(cpl), .cpl_valid_in(cv), .rx_hdr_in(rh),
    .rx_hdr_valid_in(rx_hv), .rx_hdr_ready_out(rx_hr), .rx_data_in(rx_d), .rx_be_in(8'hff),
    .rx_data_valid_in(rx_dv), .rx_data_ready_out(rx_dr), .cpl_hdr_out(ch), .cpl_hdr_valid_out(chv),
    .cpl_data_out(cd), .cpl_data_valid_out(cdv), .mst_req_out(mreq), .mst_waitrequest_in(mw),
    .mst_rvalid_in(mrv), .mst_rdata_in(md), .cr_req_in(cr), .cr_rdata_out(crd), .cr_rvalid_out(crv),
    .cr_err_out(cre));
  pmb_link_fabric_model i_pmb_link_fabric_model (.clk_in(clk_in), .arst_n_in(arst_n_in), .hdr_in(th),
    .take_in(hv & hr), .mreq_in(mreq), .cpl_out(cpl), .cpl_valid_out(cv), .wait_out(mw), .rvalid_out(mrv),
    .rdata_out(md));
  // ====
  // Stimulus and checking.
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    lfsr <= lfsr_next(lfsr);
    hr <= lfsr[0] | lfsr[1];
    dr <= lfsr[2] | lfsr[3];
  end
  task automatic chk(string n, ref logic [95:0] q[$], input logic [95:0] g);
    logic [95:0] e;
    e = (q.size() > 0) ? q.pop_front() : ~g;
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  always @(posedge clk_in) begin
    if (hv && hr) chk("tx_hdr", q_th, 96'(th));
    if (rv || wab) chk("slave", q_sl, 96'({wab, rab, rv ? rd : 64'h0}));
    if (dv && dr) chk("tx_data", q_td, 96'({tbe, td}));
    if (cdv) chk("cpl_data", q_d, 96'(cd));
    if (mreq.write && !mw && rx_dv) chk("master", q_m, {mreq.address, mreq.writedata});
    if (chv) chk("cpl_hdr", q_c, 96'(ch));
    if (crv || cre) chk("control", q_cr, 96'({cre, crd}));
  end
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic drain;
    for (int t = 0; t < 3000 && q_th.size() + q_sl.size() + q_m.size() + q_c.size() + q_cr.size() +
                    q_d.size() + q_td.size() > 0; t++)
      @(posedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic av(logic wr, logic [31:0] a, logic [6:0] bc);
    int b;
    b = 0;
    sreq <= '{~wr, wr, a, bc, 8'hff, {4{lfsr}}};
    for (int t = 0; t < 3000 && b < (wr ? int'(bc) : 1); t++) begin
      @(posedge clk_in);
      if (!wreq) begin
        b++;
        if (wr && a[2:0] == 3'h0) q_td.push_back(96'({sreq.byteenable, sreq.writedata}));
        sreq.writedata <= {4{lfsr}};
      end
    end
    sreq.read <= 1'b0;
    sreq.write <= 1'b0;
    drain;
  endtask
  task automatic crq(logic r, logic [5:0] a, logic [6:0] bc, logic [31:0] d, logic [32:0] e);
    cr <= '{r, ~r, a, bc, d};
    if (r) q_cr.push_back(96'(e));
    @(posedge clk_in);
    cr <= '0;
    @(posedge clk_in);
  endtask
  task automatic rx(pmb_pkg::pmb_rx_kind_e k, logic [2:0] bar, logic [12:0] len);
    logic [63:0] d;
    for (int i = 0; i < len / 8 && k == pmb_pkg::PMB_MEM_RD && bar < 3'h6; i++)
      q_d.push_back(96'(pmb_pkg::BAR_BASE[bar] + 32'h20 + 32'(8 * i)));
    rh <= '{k, bar, 32'h20, len};
    rx_hv <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge clk_in);
      if (rx_hr) break;
    end
    rx_hv <= 1'b0;
    for (int i = 0; i < len / 8 && k == pmb_pkg::PMB_MEM_WR; i++) begin
      d = {4{lfsr}} ^ 64'(i);
      rx_d <= d;
      rx_dv <= 1'b1;
      q_m.push_back({pmb_pkg::BAR_BASE[bar] + 32'h20, d});
      for (int t = 0; t < 100; t++) begin
        @(posedge clk_in);
        if (rx_dr) break;
      end
    end
    rx_dv <= 1'b0;
    drain;
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    crq(0, 6'h18, 7'h1, 32'h0050_0001, 0);
    crq(0, 6'h1c, 7'h1, 32'h0000_0001, 0);
    crq(1, 6'h18, 7'h1, 0, {1'b0, 32'h0050_0001});
    crq(1, 6'h18, 7'h2, 0, {1'b1, 32'h0});
    crq(1, 6'h20, 7'h1, 0, {1'b1, 32'h0});
    q_th.push_back(96'({2'b11, 64'h1_0050_0ff8, 8'h2, 6'h0}));
    q_th.push_back(96'({2'b11, 64'h1_0050_1000, 8'h2, 6'h1}));
    av(1, 32'h0030_0ff8, 7'h2);
    q_th.push_back(96'({2'b10, 64'h0, 8'h20, 6'h0}));
    q_th.push_back(96'({2'b10, 64'h80, 8'h20, 6'h10}));
    av(1, 32'h0, 7'h20);
    mp <= 2'h3;
    q_th.push_back(96'({2'b10, 64'h0, 8'h80, 6'h0}));
    av(1, 32'h0, 7'h40);
    q_th.push_back(96'({2'b00, 64'hf80, 8'h20, 6'h0}));
    q_th.push_back(96'({2'b00, 64'h1000, 8'h40, 6'h10}));
    q_th.push_back(96'({2'b00, 64'h1100, 8'h20, 6'h30}));
    for (int k = 0; k < 64; k++) q_sl.push_back(96'({2'b00, 64'hc0de_0000_0000_0000 | 64'(k)}));
    av(0, 32'h0000_0f80, 7'h40);
    repeat (2) q_sl.push_back(96'(66'h1_0000_0000_0000_0000));
    av(0, 32'h0040_0000, 7'h2);
    q_sl.push_back(96'(66'h2_0000_0000_0000_0000));
    av(1, 32'h0000_0004, 7'h1);
    rx(pmb_pkg::PMB_VDM0, 3'h0, 13'h0);
    rx(pmb_pkg::PMB_VDM1, 3'h0, 13'h0);
    q_c.push_back(96'(2'b01));
    rx(pmb_pkg::PMB_FLUSH, 3'h0, 13'h0);
    q_c.push_back(96'(2'b10));
    rx(pmb_pkg::PMB_MEM_RD, 3'h6, 13'h8);
    rx(pmb_pkg::PMB_MEM_RD, 3'h1, 13'h400);
    rx(pmb_pkg::PMB_MEM_WR, 3'h2, 13'h10);
    miscompares += q_th.size() + q_sl.size() + q_m.size() + q_c.size() + q_cr.size() + q_d.size() + q_td.size();
    test_done;
  end
  initial begin
    #500us;
    miscompares++;
    test_done;
  end
endmodule // tb_pmb_bridge
